// ### hw/lcd_i2c_pkg.sv
package lcd_i2c_pkg;

	// two-wire slave address window
	localparam logic [6:0] SLAVE_ADDR_FIRST = 7'h3C;
	localparam logic [6:0] SLAVE_ADDR_LAST  = 7'h3F;
	localparam logic [3:0] BITS_PER_BYTE    = 4'h8;

	// display RAM geometry
	localparam int         TEXT_DEPTH       = 80;
	localparam int         GLYPH_DEPTH      = 64;
	localparam logic [6:0] ONE_LINE_LAST    = 7'h4F;
	localparam logic [6:0] ROW1_FIRST       = 7'h00;
	localparam logic [6:0] ROW1_LAST        = 7'h27;
	localparam logic [6:0] ROW2_FIRST       = 7'h40;
	localparam logic [6:0] ROW2_LAST        = 7'h67;
	localparam logic [7:0] ROW_LEN_TWO      = 8'h28;
	localparam logic [7:0] ROW_LEN_ONE      = 8'h50;
	localparam logic [7:0] BLANK_CHAR       = 8'h20;

	// internal operation time
	localparam int         CLK_PERIOD_NS    = 5;
	localparam int         BUSY_TIME_NS     = 27000;
	localparam int         BUSY_CYCLES      = (BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int         BUSY_COUNT_W     = 20;

	// register map, byte addresses
	localparam logic [7:0] REG_STATUS       = 8'h00;
	localparam logic [7:0] REG_CONTROL      = 8'h04;
	localparam logic [7:0] REG_RAM_INDEX    = 8'h08;
	localparam logic [7:0] REG_RAM_DATA     = 8'h0C;
	localparam logic [7:0] REG_DISPLAY_MAP  = 8'h10;

	// field positions
	localparam int         ST_BUSY_BIT      = 7;
	localparam int         ST_TWO_LINE_BIT  = 8;
	localparam int         ST_INC_BIT       = 9;
	localparam int         ST_DISP_ON_BIT   = 10;
	localparam int         ST_GLYPH_BIT     = 11;
	localparam int         ST_SHIFT_LSB     = 12;
	localparam int         CTL_ENABLE_BIT   = 0;
	localparam int         MAP_ROW_BIT      = 8;
	localparam int         MAP_ADDR_LSB     = 16;

	localparam logic [1:0] RESP_OKAY        = 2'h0;
	localparam logic [1:0] RESP_SLVERR      = 2'h2;

	typedef enum logic [2:0] {
		PH_IDLE   = 3'b000,
		PH_ADDR   = 3'b001,
		PH_CTRL   = 3'b010,
		PH_DATA   = 3'b011,
		PH_IGNORE = 3'b100
	} phase_type;

endpackage

// ### hw/lcd_i2c_write_receiver.sv
// Functional notes
// - answer addresses 0x3C through 0x3F only
// - acknowledge match, else ignore until START
// - command word is control byte plus data
// - cleared top bit ends control bytes
// - acknowledge every control and data byte
// - select one: store RAM, advance pointer
// - select zero: decode byte as instruction
// - data byte buffered, moved into target RAM
// - instruction register written only, never read
// - busy flag blocks new instructions
// - counter loaded by instruction, steps by one
// - status shows counter beside busy flag
// - eighty character codes, all usable
// - one-line mode shows from address zero
// - two-line rows start 0x00 and 0x40
// - shift rotates each row by one
// - START and STOP seen while clock high
// - acknowledge holds data low through ninth pulse
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module lcd_i2c_write_receiver #(
	parameter int BUSY_CYCLES = lcd_i2c_pkg::BUSY_CYCLES
) (
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_o,
	output logic             busy_flag_o,
	output logic [6:0]       address_counter_o,
	output logic             two_line_o,
	input  wire logic        axi_awvalid_i,
	output logic             axi_awready_o,
	input  wire logic [7:0]  axi_awaddr_i,
	input  wire logic        axi_wvalid_i,
	output logic             axi_wready_o,
	input  wire logic [31:0] axi_wdata_i,
	input  wire logic [3:0]  axi_wstrb_i,
	output logic             axi_bvalid_o,
	input  wire logic        axi_bready_i,
	output logic [1:0]       axi_bresp_o,
	input  wire logic        axi_arvalid_i,
	output logic             axi_arready_o,
	input  wire logic [7:0]  axi_araddr_i,
	output logic             axi_rvalid_o,
	input  wire logic        axi_rready_i,
	output logic [31:0]      axi_rdata_o,
	output logic [1:0]       axi_rresp_o
);

	localparam logic [lcd_i2c_pkg::BUSY_COUNT_W-1:0] BUSY_LOAD =
		lcd_i2c_pkg::BUSY_COUNT_W'(BUSY_CYCLES);

	typedef struct packed {
		logic [1:0]                               scl_sync;
		logic [1:0]                               sda_sync;
		logic                                     scl_prev;
		logic                                     sda_prev;
		lcd_i2c_pkg::phase_type                   phase;
		logic [3:0]                               bit_cnt;
		logic [7:0]                               shift;
		logic                                     ack_drive;
		logic                                     more_ctrl;
		logic                                     register_select;
		logic [7:0]                               data_holding_register;
		logic [7:0]                               instruction_holding_register;
		logic [6:0]                               address_counter;
		logic                                     glyph_target;
		logic                                     increment;
		logic                                     two_line;
		logic                                     display_on;
		logic [6:0]                               display_shift;
		logic [lcd_i2c_pkg::BUSY_COUNT_W-1:0]     busy_count;
		logic                                     bus_enable;
		logic [6:0]                               ram_index;
		logic [5:0]                               map_column;
		logic                                     map_row;
		logic [lcd_i2c_pkg::TEXT_DEPTH-1:0][7:0]  character_display_ram;
		logic [lcd_i2c_pkg::GLYPH_DEPTH-1:0][7:0] user_glyph_ram;
		logic                                     aw_held;
		logic                                     w_held;
		logic [7:0]                               aw_addr;
		logic [31:0]                              w_data;
		logic [3:0]                               w_strb;
		logic                                     bvalid;
		logic [1:0]                               bresp;
		logic                                     rvalid;
		logic [31:0]                              rdata;
		logic [1:0]                               rresp;
	} state_type;

	state_type state;
	state_type next_state;

	// display address to physical slot; all ones outside the mode's ranges
	function automatic logic [7:0] display_slot(input logic [6:0] addr, input logic two);
		logic [7:0] slot;
		slot = 8'hFF;
		if (!two) begin
			if (addr <= lcd_i2c_pkg::ONE_LINE_LAST) begin
				slot = {1'b0, addr};
			end
		end else if (addr <= lcd_i2c_pkg::ROW1_LAST) begin
			slot = {1'b0, addr};
		end else if (addr >= lcd_i2c_pkg::ROW2_FIRST && addr <= lcd_i2c_pkg::ROW2_LAST) begin
			slot = {1'b0, addr - lcd_i2c_pkg::ROW2_FIRST} + lcd_i2c_pkg::ROW_LEN_TWO;
		end
		return slot;
	endfunction

	// counter step by one with wrap per target and line mode
	function automatic logic [6:0] step_addr(input logic [6:0] addr, input logic up,
			input logic glyph, input logic two);
		logic [6:0] res;
		res = up ? addr + 7'h01 : addr - 7'h01;
		if (glyph) begin
			res = {1'b0, res[5:0]};
		end else if (!two) begin
			if (up && addr == lcd_i2c_pkg::ONE_LINE_LAST) begin
				res = lcd_i2c_pkg::ROW1_FIRST;
			end else if (!up && addr == lcd_i2c_pkg::ROW1_FIRST) begin
				res = lcd_i2c_pkg::ONE_LINE_LAST;
			end
		end else if (up) begin
			if (addr == lcd_i2c_pkg::ROW1_LAST) begin
				res = lcd_i2c_pkg::ROW2_FIRST;
			end else if (addr == lcd_i2c_pkg::ROW2_LAST) begin
				res = lcd_i2c_pkg::ROW1_FIRST;
			end
		end else begin
			if (addr == lcd_i2c_pkg::ROW1_FIRST) begin
				res = lcd_i2c_pkg::ROW2_LAST;
			end else if (addr == lcd_i2c_pkg::ROW2_FIRST) begin
				res = lcd_i2c_pkg::ROW1_LAST;
			end
		end
		return res;
	endfunction

	function automatic logic [7:0] wrap_len(input logic [7:0] value, input logic [7:0] len);
		logic [7:0] res;
		res = value;
		if (res >= len) begin
			res = res - len;
		end
		if (res >= len) begin
			res = res - len;
		end
		return res;
	endfunction

	// address shown at a column and row for the current shift
	function automatic logic [6:0] shown_addr(input logic [5:0] col, input logic row,
			input logic [6:0] shift, input logic two);
		logic [7:0] pos;
		pos = {2'h0, col} + {1'b0, shift};
		if (two) begin
			pos = wrap_len(pos, lcd_i2c_pkg::ROW_LEN_TWO);
			return (row ? lcd_i2c_pkg::ROW2_FIRST : lcd_i2c_pkg::ROW1_FIRST) + pos[6:0];
		end
		pos = wrap_len(pos, lcd_i2c_pkg::ROW_LEN_ONE);
		return pos[6:0];
	endfunction

	function automatic logic [6:0] step_shift(input logic [6:0] shift, input logic left,
			input logic two);
		logic [6:0] last;
		last = two ? 7'(lcd_i2c_pkg::ROW_LEN_TWO - 8'h01) : 7'(lcd_i2c_pkg::ROW_LEN_ONE - 8'h01);
		if (left) begin
			return (shift >= last) ? 7'h00 : shift + 7'h01;
		end
		return (shift == 7'h00 || shift > last) ? last : shift - 7'h01;
	endfunction

	function automatic logic reg_mapped(input logic [7:0] addr);
		return addr == lcd_i2c_pkg::REG_STATUS || addr == lcd_i2c_pkg::REG_CONTROL ||
			addr == lcd_i2c_pkg::REG_RAM_INDEX || addr == lcd_i2c_pkg::REG_RAM_DATA ||
			addr == lcd_i2c_pkg::REG_DISPLAY_MAP;
	endfunction

	// instruction holding register has no read path
	function automatic logic [31:0] read_reg(input state_type s, input logic [7:0] addr);
		logic [31:0] val;
		logic [7:0]  slot;
		val  = 32'h0000_0000;
		slot = display_slot(s.ram_index, s.two_line);
		unique case (addr)
			lcd_i2c_pkg::REG_STATUS: begin
				val[6:0]                          = s.address_counter;
				val[lcd_i2c_pkg::ST_BUSY_BIT]     = (s.busy_count != '0);
				val[lcd_i2c_pkg::ST_TWO_LINE_BIT] = s.two_line;
				val[lcd_i2c_pkg::ST_INC_BIT]      = s.increment;
				val[lcd_i2c_pkg::ST_DISP_ON_BIT]  = s.display_on;
				val[lcd_i2c_pkg::ST_GLYPH_BIT]    = s.glyph_target;
				val[lcd_i2c_pkg::ST_SHIFT_LSB +: 7] = s.display_shift;
			end
			lcd_i2c_pkg::REG_CONTROL:   val[lcd_i2c_pkg::CTL_ENABLE_BIT] = s.bus_enable;
			lcd_i2c_pkg::REG_RAM_INDEX: val[6:0] = s.ram_index;
			lcd_i2c_pkg::REG_RAM_DATA: begin
				if (slot != 8'hFF) begin
					val[7:0] = s.character_display_ram[slot[6:0]];
				end
			end
			lcd_i2c_pkg::REG_DISPLAY_MAP: begin
				val[5:0]                          = s.map_column;
				val[lcd_i2c_pkg::MAP_ROW_BIT]     = s.map_row;
				val[lcd_i2c_pkg::MAP_ADDR_LSB +: 7] =
					shown_addr(s.map_column, s.map_row, s.display_shift, s.two_line);
			end
			default: val = 32'h0000_0000;
		endcase
		return val;
	endfunction

	always_comb begin
		logic       scl_rise;
		logic       scl_fall;
		logic       start_seen;
		logic       stop_seen;
		logic [7:0] byte_in;
		logic [7:0] slot;
		logic [31:0] merged;
		scl_rise   = 1'b0;
		scl_fall   = 1'b0;
		start_seen = 1'b0;
		stop_seen  = 1'b0;
		byte_in    = 8'h00;
		slot       = 8'hFF;
		merged     = 32'h0000_0000;
		next_state = state;
		if (ce_i) begin
			next_state.scl_sync = {state.scl_sync[0], scl_i};
			next_state.sda_sync = {state.sda_sync[0], sda_i};
			next_state.scl_prev = state.scl_sync[1];
			next_state.sda_prev = state.sda_sync[1];
			scl_rise   = state.scl_sync[1] && !state.scl_prev;
			scl_fall   = !state.scl_sync[1] && state.scl_prev;
			start_seen = state.scl_sync[1] && state.scl_prev && state.sda_prev && !state.sda_sync[1];
			stop_seen  = state.scl_sync[1] && state.scl_prev && !state.sda_prev && state.sda_sync[1];
			if (state.busy_count != '0) begin
				next_state.busy_count = state.busy_count - 1'b1;
			end

			if (stop_seen || !state.bus_enable) begin
				next_state.phase     = lcd_i2c_pkg::PH_IDLE;
				next_state.bit_cnt   = 4'h0;
				next_state.ack_drive = 1'b0;
			end else if (start_seen) begin
				next_state.phase     = lcd_i2c_pkg::PH_ADDR;
				next_state.bit_cnt   = 4'h0;
				next_state.ack_drive = 1'b0;
			end else if (state.phase != lcd_i2c_pkg::PH_IDLE &&
					state.phase != lcd_i2c_pkg::PH_IGNORE) begin
				if (scl_rise && state.bit_cnt < lcd_i2c_pkg::BITS_PER_BYTE) begin
					next_state.shift   = {state.shift[6:0], state.sda_sync[1]};
					next_state.bit_cnt = state.bit_cnt + 4'h1;
				end else if (scl_fall && state.ack_drive) begin
					next_state.ack_drive = 1'b0;
					next_state.bit_cnt   = 4'h0;
				end else if (scl_fall && state.bit_cnt == lcd_i2c_pkg::BITS_PER_BYTE) begin
					byte_in = state.shift;
					unique case (state.phase)
						lcd_i2c_pkg::PH_ADDR: begin
							if (byte_in[7:1] >= lcd_i2c_pkg::SLAVE_ADDR_FIRST &&
									byte_in[7:1] <= lcd_i2c_pkg::SLAVE_ADDR_LAST &&
									!byte_in[0]) begin
								next_state.ack_drive = 1'b1;
								next_state.phase     = lcd_i2c_pkg::PH_CTRL;
							end else begin
								next_state.phase = lcd_i2c_pkg::PH_IGNORE;
							end
						end
						lcd_i2c_pkg::PH_CTRL: begin
							next_state.ack_drive       = 1'b1;
							next_state.more_ctrl       = byte_in[7];
							next_state.register_select = byte_in[6];
							next_state.phase           = lcd_i2c_pkg::PH_DATA;
						end
						default: begin
							next_state.ack_drive = 1'b1;
							next_state.phase     = state.more_ctrl ? lcd_i2c_pkg::PH_CTRL
								: lcd_i2c_pkg::PH_DATA;
							if (state.busy_count == '0) begin
								next_state.busy_count = BUSY_LOAD;
								if (state.register_select) begin
									next_state.data_holding_register = byte_in;
									if (state.glyph_target) begin
										next_state.user_glyph_ram[state.address_counter[5:0]] =
											byte_in;
									end else begin
										slot = display_slot(state.address_counter, state.two_line);
										if (slot != 8'hFF) begin
											next_state.character_display_ram[slot[6:0]] =
												byte_in;
										end
									end
									next_state.address_counter = step_addr(state.address_counter,
										state.increment, state.glyph_target, state.two_line);
								end else begin
									next_state.instruction_holding_register = byte_in;
									if (byte_in[7]) begin
										next_state.address_counter = byte_in[6:0];
										next_state.glyph_target    = 1'b0;
									end else if (byte_in[6]) begin
										next_state.address_counter = {1'b0, byte_in[5:0]};
										next_state.glyph_target    = 1'b1;
									end else if (byte_in[5]) begin
										next_state.two_line      = byte_in[3];
										next_state.display_shift = 7'h00;
									end else if (byte_in[4]) begin
										if (byte_in[3]) begin
											next_state.display_shift = step_shift(state.display_shift,
												!byte_in[2], state.two_line);
										end else begin
											next_state.address_counter = step_addr(state.address_counter,
												byte_in[2], state.glyph_target, state.two_line);
										end
									end else if (byte_in[3]) begin
										next_state.display_on = byte_in[2];
									end else if (byte_in[2]) begin
										next_state.increment = byte_in[1];
									end else if (byte_in[1]) begin
										next_state.address_counter = lcd_i2c_pkg::ROW1_FIRST;
										next_state.display_shift   = 7'h00;
										next_state.glyph_target    = 1'b0;
									end else if (byte_in[0]) begin
										for (int i = 0; i < lcd_i2c_pkg::TEXT_DEPTH; i++) begin
											next_state.character_display_ram[i] = lcd_i2c_pkg::BLANK_CHAR;
										end
										next_state.address_counter = lcd_i2c_pkg::ROW1_FIRST;
										next_state.display_shift   = 7'h00;
										next_state.increment       = 1'b1;
										next_state.glyph_target    = 1'b0;
									end
								end
							end
						end
					endcase
				end
			end

			// register bus
			if (axi_awvalid_i && axi_awready_o) begin
				next_state.aw_held = 1'b1;
				next_state.aw_addr = axi_awaddr_i;
			end
			if (axi_wvalid_i && axi_wready_o) begin
				next_state.w_held = 1'b1;
				next_state.w_data = axi_wdata_i;
				next_state.w_strb = axi_wstrb_i;
			end
			if (state.aw_held && state.w_held && !state.bvalid) begin
				next_state.aw_held = 1'b0;
				next_state.w_held  = 1'b0;
				next_state.bvalid  = 1'b1;
				next_state.bresp   = reg_mapped(state.aw_addr) ? lcd_i2c_pkg::RESP_OKAY
					: lcd_i2c_pkg::RESP_SLVERR;
				merged = read_reg(state, state.aw_addr);
				for (int b = 0; b < 4; b++) begin
					if (state.w_strb[b]) begin
						merged[b*8 +: 8] = state.w_data[b*8 +: 8];
					end
				end
				unique case (state.aw_addr)
					lcd_i2c_pkg::REG_CONTROL:
						next_state.bus_enable = merged[lcd_i2c_pkg::CTL_ENABLE_BIT];
					lcd_i2c_pkg::REG_RAM_INDEX:
						next_state.ram_index = merged[6:0];
					lcd_i2c_pkg::REG_DISPLAY_MAP: begin
						next_state.map_column = merged[5:0];
						next_state.map_row    = merged[lcd_i2c_pkg::MAP_ROW_BIT];
					end
					default: next_state.bus_enable = state.bus_enable;
				endcase
			end
			if (state.bvalid && axi_bready_i) begin
				next_state.bvalid = 1'b0;
			end
			if (state.rvalid && axi_rready_i) begin
				next_state.rvalid = 1'b0;
			end
			if (axi_arvalid_i && axi_arready_o) begin
				next_state.rvalid = 1'b1;
				next_state.rdata  = read_reg(state, axi_araddr_i);
				next_state.rresp  = reg_mapped(axi_araddr_i) ? lcd_i2c_pkg::RESP_OKAY
					: lcd_i2c_pkg::RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			state            <= '0;
			state.scl_sync   <= 2'h3;
			state.sda_sync   <= 2'h3;
			state.scl_prev   <= 1'b1;
			state.sda_prev   <= 1'b1;
			state.increment  <= 1'b1;
			state.bus_enable <= 1'b1;
		end else begin
			state <= next_state;
		end
	end

	assign sda_o             = 1'b0;
	assign sda_oe_o          = state.ack_drive;
	assign busy_flag_o       = (state.busy_count != '0);
	assign address_counter_o = state.address_counter;
	assign two_line_o        = state.two_line;
	assign axi_awready_o     = ce_i && !state.aw_held && !state.bvalid;
	assign axi_wready_o      = ce_i && !state.w_held && !state.bvalid;
	assign axi_bvalid_o      = state.bvalid;
	assign axi_bresp_o       = state.bresp;
	assign axi_arready_o     = ce_i && !state.rvalid;
	assign axi_rvalid_o      = state.rvalid;
	assign axi_rdata_o       = state.rdata;
	assign axi_rresp_o       = state.rresp;

endmodule
`default_nettype wire

// ### verification/i2c_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
	input  wire logic core_clk_i,
	input  wire logic sda_line_i,
	output logic      scl_o,
	output logic      sda_o
);
	logic ack;
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
		ack = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask
	task automatic start();
		sda_o <= 1'b1;
		hold(4);
		scl_o <= 1'b1;
		hold(4);
		sda_o <= 1'b0;
		hold(4);
		scl_o <= 1'b0;
		hold(4);
	endtask
	// byte time far above the busy time, so busy is always clear
	task automatic send(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			sda_o <= b[i];
			hold(4);
			scl_o <= 1'b1;
			hold(8);
			scl_o <= 1'b0;
			hold(4);
		end
		sda_o <= 1'b1;
		hold(4);
		scl_o <= 1'b1;
		hold(4);
		ack = !sda_line_i;
		hold(4);
		scl_o <= 1'b0;
		hold(4);
	endtask
	task automatic stop();
		sda_o <= 1'b0;
		hold(4);
		scl_o <= 1'b1;
		hold(4);
		sda_o <= 1'b1;
		hold(8);
	endtask
endmodule
`default_nettype wire

// ### verification/lcd_i2c_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_i2c_monitor #(
	parameter int BUSY_CYCLES = 20
) (
	input wire logic       core_clk_i,
	input wire logic       rst_i,
	input wire logic       scl_i,
	input wire logic       sda_i,
	input wire logic       sda_o,
	input wire logic       sda_oe_o,
	input wire logic       busy_flag_o,
	input wire logic [6:0] address_counter_o,
	input wire logic       two_line_o,
	input wire logic       axi_bvalid_o,
	input wire logic       axi_bready_i,
	input wire logic       axi_rvalid_o,
	input wire logic       axi_rready_i,
	input wire logic       axi_arready_o
);
	logic [19:0] busy_cnt;
	// length of the current busy run
	always_ff @(posedge core_clk_i) begin
		busy_cnt <= (rst_i || !busy_flag_o) ? 20'h00000 : busy_cnt + 20'h00001;
	end
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);
	chk_sda_low: assert property (sda_o == 1'b0)
		else $error("sda drive value not zero");
	chk_ack_clk_low: assert property ($rose(sda_oe_o) |-> !scl_i)
		else $error("ack raised while clock high");
	chk_ack_steady: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
		else $error("ack changed while clock high");
	chk_stop_idle: assert property (scl_i && sda_i && !$past(sda_i) |=> !sda_oe_o [*8])
		else $error("ack driven after stop");
	chk_busy_len: assert property ($fell(busy_flag_o) |-> busy_cnt == BUSY_CYCLES)
		else $error("busy run length wrong");
	chk_busy_ctr: assert property (busy_flag_o && $past(busy_flag_o, 2) |-> $stable(address_counter_o))
		else $error("counter moved while busy");
	chk_busy_mode: assert property ($rose(busy_flag_o) |=> ##1 $stable(two_line_o) [*8])
		else $error("line mode moved while busy");
	chk_b_release: assert property (axi_bvalid_o && axi_bready_i |=> !axi_bvalid_o)
		else $error("write response not released");
	chk_r_release: assert property (axi_rvalid_o && axi_rready_i |=> !axi_rvalid_o)
		else $error("read response not released");
	chk_ar_block: assert property (axi_rvalid_o |-> !axi_arready_o)
		else $error("read address taken while answer pending");
endmodule
bind lcd_i2c_write_receiver lcd_i2c_monitor #(.BUSY_CYCLES(BUSY_CYCLES)) lcd_i2c_monitor_i (
	.core_clk_i(core_clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i),
	.sda_o(sda_o), .sda_oe_o(sda_oe_o), .busy_flag_o(busy_flag_o),
	.address_counter_o(address_counter_o), .two_line_o(two_line_o),
	.axi_bvalid_o(axi_bvalid_o), .axi_bready_i(axi_bready_i), .axi_rvalid_o(axi_rvalid_o),
	.axi_rready_i(axi_rready_i), .axi_arready_o(axi_arready_o)
);
`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
	samples_checked++; \
	if ((g) !== (e)) begin \
		miscompares++; \
		$display("MISMATCH %0t got %h exp %h", $time, g, e); \
	end \
end
module tb_top;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        ce = 1'b1;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic [31:0] rd;
	logic [31:0] rdata;
	logic [1:0]  resp;
	logic [1:0]  bresp;
	logic [1:0]  rresp;
	logic [6:0]  counter;
	logic [7:0]  bad [3] = '{8'h76, 8'h79, 8'h80};
	logic        awready, wready, bvalid, arready, rvalid, sda_oe, sda_drv;
	logic        busy, two_line, scl, msda, sda;
	int          miscompares = 0;
	int          samples_checked = 0;
	int          t = 1;
	assign sda = msda & ~sda_oe;
	always #2.5 clk = ~clk;
	lcd_i2c_write_receiver #(.BUSY_CYCLES(20)) lcd_i2c_write_receiver_i (
		.core_clk_i(clk), .rst_i(rst), .ce_i(ce), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_drv), .sda_oe_o(sda_oe), .busy_flag_o(busy), .address_counter_o(counter),
		.two_line_o(two_line), .axi_awvalid_i(awvalid), .axi_awready_o(awready),
		.axi_awaddr_i(awaddr), .axi_wvalid_i(wvalid), .axi_wready_o(wready),
		.axi_wdata_i(wdata), .axi_wstrb_i(4'hF), .axi_bvalid_o(bvalid), .axi_bready_i(bready),
		.axi_bresp_o(bresp), .axi_arvalid_i(arvalid), .axi_arready_o(arready),
		.axi_araddr_i(araddr), .axi_rvalid_o(rvalid), .axi_rready_i(rready),
		.axi_rdata_o(rdata), .axi_rresp_o(rresp)
	);
	i2c_master_model i2c_master_model_i (
		.core_clk_i(clk), .sda_line_i(sda), .scl_o(scl), .sda_o(msda)
	);
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic expire(input logic done);
		if (!done) begin
			miscompares++;
			$display("MISMATCH %0t wait timed out", $time);
			conclude();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw, done;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		done = 1'b0;
		for (int n = 0; n < 100 && !done; n++) begin
			@(negedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			done = bvalid;
			resp = bresp;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		// one idle edge so a following call never re-raises the ready in this step
		@(posedge clk);
		expire(done);
		`CHK(resp, er)
	endtask
	task automatic rd_reg(input logic [7:0] a);
		logic ta, done;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		done = 1'b0;
		for (int n = 0; n < 100 && !done; n++) begin
			@(negedge clk);
			ta = arvalid && arready;
			done = rvalid;
			rd = rdata;
			resp = rresp;
			@(posedge clk);
			if (ta) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		@(posedge clk);
		expire(done);
	endtask
	task automatic frame(input logic [7:0] q[$], input logic ea);
		int n;
		i2c_master_model_i.start();
		foreach (q[i]) begin
			i2c_master_model_i.send(q[i]);
			`CHK(i2c_master_model_i.ack, ea)
		end
		i2c_master_model_i.stop();
		for (n = 0; n < 100 && busy; n++)
			@(posedge clk);
		expire(n < 100);
	endtask
	task automatic map(input logic [31:0] v);
		wr(lcd_i2c_pkg::REG_DISPLAY_MAP, v, lcd_i2c_pkg::RESP_OKAY);
		rd_reg(lcd_i2c_pkg::REG_DISPLAY_MAP);
	endtask
	task automatic tend();
		$display("test %0d done", t);
		t++;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		rd_reg(lcd_i2c_pkg::REG_STATUS);
		`CHK(rd[9:0], 10'h200)
		rd_reg(8'h14);
		`CHK({resp, rd}, {lcd_i2c_pkg::RESP_SLVERR, 32'h00000000})
		wr(8'h14, 32'h000000FF, lcd_i2c_pkg::RESP_SLVERR);
		wr(lcd_i2c_pkg::REG_CONTROL, 32'h00000001, lcd_i2c_pkg::RESP_OKAY);
		tend();
		frame('{8'h78, 8'h80, 8'h38, 8'h40, 8'h41, 8'h42}, 1'b1);
		`CHK(two_line, 1'b1)
		`CHK(counter, 7'h02)
		wr(lcd_i2c_pkg::REG_RAM_INDEX, 32'h00000000, lcd_i2c_pkg::RESP_OKAY);
		rd_reg(lcd_i2c_pkg::REG_RAM_DATA);
		`CHK(rd[7:0], 8'h41)
		tend();
		frame('{8'h7E, 8'h80, 8'hA7, 8'h40, 8'h55}, 1'b1);
		`CHK(counter, lcd_i2c_pkg::ROW2_FIRST)
		wr(lcd_i2c_pkg::REG_RAM_INDEX, 32'h00000027, lcd_i2c_pkg::RESP_OKAY);
		rd_reg(lcd_i2c_pkg::REG_RAM_DATA);
		`CHK(rd[7:0], 8'h55)
		tend();
		foreach (bad[i])
			frame('{bad[i], 8'hC0, 8'h99}, 1'b0);
		`CHK(counter, lcd_i2c_pkg::ROW2_FIRST)
		// bus switched off: no acknowledge, no store
		wr(lcd_i2c_pkg::REG_CONTROL, 32'h00000000, lcd_i2c_pkg::RESP_OKAY);
		frame('{8'h78, 8'h40, 8'h33}, 1'b0);
		`CHK(counter, lcd_i2c_pkg::ROW2_FIRST)
		wr(lcd_i2c_pkg::REG_CONTROL, 32'h00000001, lcd_i2c_pkg::RESP_OKAY);
		// clock enable low refuses every register request
		ce <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK({arready, awready, wready}, 3'h0)
		ce <= 1'b1;
		tend();
		frame('{8'h7A, 8'h00, 8'h1C}, 1'b1);
		map(32'h00000000);
		`CHK(rd[22:16], 7'h27)
		map(32'h00000100);
		`CHK(rd[22:16], 7'h67)
		frame('{8'h7C, 8'h00, 8'h18, 8'h18}, 1'b1);
		map(32'h00000000);
		`CHK(rd[22:16], 7'h01)
		frame('{8'h78, 8'h00, 8'h30}, 1'b1);
		`CHK(two_line, 1'b0)
		map(32'h00000013);
		`CHK(rd[22:16], 7'h13)
		tend();
		conclude();
	end
endmodule
`default_nettype wire
